// File: lrfc_pkg.sv
// Package for the legacy remap fault checker: constants, codes, carriers.
// Assumes a single 10 MHz clock domain and an Avalon-MM register master.
package lrfc_pkg;

  localparam int ADDR_W = 64;

  // Fault reason codes
  localparam logic [7:0] FR_NONE = 8'h00;
  localparam logic [7:0] FR_OVERFLOW = 8'h04;
  localparam logic [7:0] FR_WRITE_DENIED = 8'h05;
  localparam logic [7:0] FR_READ_DENIED = 8'h06;
  localparam logic [7:0] FR_WALK_ACCESS = 8'h07;
  localparam logic [7:0] FR_ENTRY_RSVD = 8'h0c;
  localparam logic [7:0] FR_INTR_WINDOW = 8'h0e;

  localparam logic [1:0] TABLE_MODE_LEGACY = 2'h0;
  localparam logic [1:0] TT_PASSTHROUGH = 2'h2;

  // Interrupt window: output address bits 31:20 equal to fee
  localparam logic [11:0] INTR_WIN_TAG = 12'hfee;
  localparam int INTR_WIN_LSB = 20;

  // Register word offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAP = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FADDR_LO = 8'h0c;
  localparam logic [7:0] OFF_FADDR_HI = 8'h10;
  localparam logic [7:0] OFF_FSRC = 8'h14;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ZLR_BIT = 2;
  localparam int CTRL_MAX_GUEST_ADDR_WIDTH_LSB = 8;
  localparam int CTRL_HAW_LSB = 16;
  localparam logic [6:0] MAX_GUEST_ADDR_WIDTH_RST = 7'h30;
  localparam logic [6:0] HAW_RST = 7'h27;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    LRFC_KIND_UNTRANSLATED = 3'h1,
    LRFC_KIND_TRANSLATION = 3'h2,
    LRFC_KIND_TRANSLATED = 3'h4
  } lrfc_kind_e;

  typedef enum logic [2:0] {
    LRFC_CPL_SUCCESS = 3'h1,
    LRFC_CPL_UR = 3'h2,
    LRFC_CPL_CA = 3'h4
  } lrfc_cpl_e;

  // One checked request with its walk and context results
  typedef struct packed {
    logic valid;
    lrfc_kind_e kind;
    logic [15:0] source_id;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] out_addr;
    logic is_write;
    logic is_read;
    logic zero_len;
    logic [1:0] translation_type;
    logic [6:0] context_addr_width;
    logic walk_access_error;
    logic entry_reserved_error;
    logic perm_read;
    logic perm_write;
    logic perm_user;
    logic perm_super;
  } lrfc_req_s;

  typedef struct packed {
    logic valid;
    lrfc_cpl_e cpl;
    logic [7:0] reason;
    logic perm_read;
    logic perm_write;
    logic perm_user;
    logic perm_super;
  } lrfc_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] reason;
    logic [15:0] source_id;
    logic [ADDR_W-1:0] addr;
  } lrfc_fault_s;

endpackage : lrfc_pkg

// File: lrfc_checker.sv
// Legacy-mode remap fault checker: one request per cycle, answer next cycle.
// Assumes request fields are synchronous to ref_clk and the walk results
// arrive with the request; the last fault record and a fault count are kept here.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module lrfc_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request in
  input wire lrfc_pkg::lrfc_req_s req,
  // Completion out
  output lrfc_pkg::lrfc_rsp_s rsp,
  // Fault record out
  output lrfc_pkg::lrfc_fault_s fault,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef struct packed {
    lrfc_pkg::lrfc_rsp_s rsp;
    lrfc_pkg::lrfc_fault_s fault;
    logic [1:0] table_mode;
    logic zlr_cap;
    logic [6:0] max_guest_addr_width;
    logic [6:0] host_addr_width;
    logic [15:0] fault_count;
    lrfc_pkg::lrfc_fault_s last;
    logic [31:0] rdata;
    logic wait_req;
  } lrfc_state_s;

  lrfc_state_s st_ff;
  lrfc_state_s nxt_st;

  // True when addr exceeds 2^width - 1
  function automatic logic above_width(
    input logic [lrfc_pkg::ADDR_W-1:0] a,
    input logic [6:0] width
  );
    logic [lrfc_pkg::ADDR_W-1:0] lim;
    lim = '1;
    if (width < 7'(lrfc_pkg::ADDR_W))
      lim = ~({lrfc_pkg::ADDR_W{1'b1}} << width);
    return a > lim;
  endfunction : above_width

  function automatic logic [31:0] bytes_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : bytes_merge

  logic legacy;
  logic [6:0] gaw;
  logic [lrfc_pkg::ADDR_W-1:0] eff_out;
  logic is_ut;
  logic is_tr;
  logic is_td;
  logic chk_walk;
  logic chk_rsvd;
  logic chk_ovf;
  logic chk_wr;
  logic chk_rd;
  logic chk_win;
  logic [31:0] ctrl_word;

  always_comb
  begin
    legacy = st_ff.table_mode == lrfc_pkg::TABLE_MODE_LEGACY;
    gaw = (st_ff.max_guest_addr_width < req.context_addr_width) ? st_ff.max_guest_addr_width
                                                  : req.context_addr_width;
    is_ut = req.kind == lrfc_pkg::LRFC_KIND_UNTRANSLATED;
    is_tr = req.kind == lrfc_pkg::LRFC_KIND_TRANSLATION;
    is_td = req.kind == lrfc_pkg::LRFC_KIND_TRANSLATED;
    // Request address stands as output address for translated and pass-through requests
    eff_out = (is_td || req.translation_type == lrfc_pkg::TT_PASSTHROUGH)
              ? req.addr : req.out_addr;
    chk_walk = (is_ut || is_tr) && req.walk_access_error;
    chk_rsvd = (is_ut || is_tr) && req.entry_reserved_error;
    chk_ovf = ((is_ut && req.translation_type != lrfc_pkg::TT_PASSTHROUGH
                || is_tr) && above_width(req.addr, gaw))
              || (is_td && above_width(req.addr, st_ff.host_addr_width))
              || (is_ut && req.translation_type == lrfc_pkg::TT_PASSTHROUGH
                  && above_width(req.addr, st_ff.host_addr_width));
    chk_wr = (is_ut || is_tr) && req.is_write && !req.perm_write;
    chk_rd = (is_ut || is_tr) && req.is_read && !req.perm_read
             && !(st_ff.zlr_cap && req.zero_len && req.perm_write);
    chk_win = eff_out[31:lrfc_pkg::INTR_WIN_LSB] == lrfc_pkg::INTR_WIN_TAG
              && eff_out[lrfc_pkg::ADDR_W-1:32] == '0;
    ctrl_word = '0;
    ctrl_word[lrfc_pkg::CTRL_MODE_LSB +: 2] = st_ff.table_mode;
    ctrl_word[lrfc_pkg::CTRL_ZLR_BIT] = st_ff.zlr_cap;
    ctrl_word[lrfc_pkg::CTRL_MAX_GUEST_ADDR_WIDTH_LSB +: 7] = st_ff.max_guest_addr_width;
    ctrl_word[lrfc_pkg::CTRL_HAW_LSB +: 7] = st_ff.host_addr_width;

    nxt_st = st_ff;
    nxt_st.rsp = '0;
    nxt_st.rsp.cpl = lrfc_pkg::LRFC_CPL_SUCCESS;
    nxt_st.fault = '0;
    nxt_st.rsp.valid = req.valid;
    nxt_st.rsp.perm_read = req.perm_read;
    nxt_st.rsp.perm_write = req.perm_write;
    nxt_st.rsp.perm_user = req.perm_user;
    nxt_st.rsp.perm_super = req.perm_super;
    // Priority: walk errors, then overflow, permissions, window
    if (req.valid && legacy)
    begin
      if (chk_walk)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_WALK_ACCESS;
        nxt_st.rsp.cpl = is_tr ? lrfc_pkg::LRFC_CPL_CA
                               : lrfc_pkg::LRFC_CPL_UR;
      end
      else if (chk_rsvd)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_ENTRY_RSVD;
        nxt_st.rsp.cpl = is_tr ? lrfc_pkg::LRFC_CPL_CA
                               : lrfc_pkg::LRFC_CPL_UR;
      end
      else if (chk_ovf)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_OVERFLOW;
        if (is_tr)
        begin
          // Success with every permission cleared
          nxt_st.rsp.perm_read = 1'b0;
          nxt_st.rsp.perm_write = 1'b0;
          nxt_st.rsp.perm_user = 1'b0;
          nxt_st.rsp.perm_super = 1'b0;
        end
        else
          nxt_st.rsp.cpl = lrfc_pkg::LRFC_CPL_UR;
      end
      else if (chk_wr)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_WRITE_DENIED;
        if (!is_tr)
          nxt_st.rsp.cpl = lrfc_pkg::LRFC_CPL_UR;
      end
      else if (chk_rd)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_READ_DENIED;
        if (!is_tr)
          nxt_st.rsp.cpl = lrfc_pkg::LRFC_CPL_UR;
      end
      else if (chk_win)
      begin
        nxt_st.rsp.reason = lrfc_pkg::FR_INTR_WINDOW;
        nxt_st.rsp.cpl = is_tr ? lrfc_pkg::LRFC_CPL_CA
                               : lrfc_pkg::LRFC_CPL_UR;
      end
    end
    if (nxt_st.rsp.reason != lrfc_pkg::FR_NONE)
    begin
      nxt_st.fault.valid = 1'b1;
      nxt_st.fault.reason = nxt_st.rsp.reason;
      nxt_st.fault.source_id = req.source_id;
      nxt_st.fault.addr = req.addr;
      nxt_st.last = nxt_st.fault;
      nxt_st.fault_count = st_ff.fault_count + 16'h0001;
    end

    // Avalon slave: one wait cycle, then ack with data
    nxt_st.wait_req = 1'b1;
    nxt_st.rdata = st_ff.rdata;
    // Writes land only at the edge that completes the transfer
    if (avs_write && !st_ff.wait_req)
    begin
      if (avs_address == lrfc_pkg::OFF_CTRL)
      begin
        ctrl_word = bytes_merge(ctrl_word, avs_writedata, avs_byteenable);
        nxt_st.table_mode = ctrl_word[lrfc_pkg::CTRL_MODE_LSB +: 2];
        nxt_st.zlr_cap = ctrl_word[lrfc_pkg::CTRL_ZLR_BIT];
        nxt_st.max_guest_addr_width = ctrl_word[lrfc_pkg::CTRL_MAX_GUEST_ADDR_WIDTH_LSB +: 7];
        nxt_st.host_addr_width = ctrl_word[lrfc_pkg::CTRL_HAW_LSB +: 7];
      end
      // Write clears count unless a fault lands in the same cycle; then the count increments
      else if (avs_address == lrfc_pkg::OFF_STATUS && !nxt_st.fault.valid)
        nxt_st.fault_count = '0;
    end
    if ((avs_read || avs_write) && st_ff.wait_req)
    begin
      nxt_st.wait_req = 1'b0;
      nxt_st.rdata = lrfc_pkg::UNMAPPED_DATA;
      if (avs_address == lrfc_pkg::OFF_CTRL)
        nxt_st.rdata = ctrl_word;
      else if (avs_address == lrfc_pkg::OFF_STATUS)
        nxt_st.rdata = {8'h00, st_ff.last.reason, st_ff.fault_count};
      else if (avs_address == lrfc_pkg::OFF_FADDR_LO)
        nxt_st.rdata = st_ff.last.addr[31:0];
      else if (avs_address == lrfc_pkg::OFF_FADDR_HI)
        nxt_st.rdata = st_ff.last.addr[63:32];
      else if (avs_address == lrfc_pkg::OFF_FSRC)
        nxt_st.rdata = {16'h0000, st_ff.last.source_id};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.rsp.cpl <= lrfc_pkg::LRFC_CPL_SUCCESS;
      st_ff.max_guest_addr_width <= lrfc_pkg::MAX_GUEST_ADDR_WIDTH_RST;
      st_ff.host_addr_width <= lrfc_pkg::HAW_RST;
      st_ff.wait_req <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign rsp = st_ff.rsp;
  assign fault = st_ff.fault;
  assign avs_readdata = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;

  property p_non_legacy_quiet;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && st_ff.table_mode != lrfc_pkg::TABLE_MODE_LEGACY)
      |=> !fault.valid;
  endproperty
  a_non_legacy_quiet: assert property (p_non_legacy_quiet)
    else $error("fault raised outside legacy mode");

  property p_walk;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && legacy && chk_walk)
      |=> fault.reason == lrfc_pkg::FR_WALK_ACCESS
          && rsp.cpl != lrfc_pkg::LRFC_CPL_SUCCESS;
  endproperty
  a_walk: assert property (p_walk)
    else $error("walk error not reported as 7h");

  property p_rsvd_tr_ca;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && legacy && !chk_walk && chk_rsvd && is_tr)
      |=> rsp.cpl == lrfc_pkg::LRFC_CPL_CA
          && rsp.reason == lrfc_pkg::FR_ENTRY_RSVD;
  endproperty
  a_rsvd_tr_ca: assert property (p_rsvd_tr_ca)
    else $error("reserved entry fault wrong for translation");

  property p_ovf_tr_noperm;
    @(posedge ref_clk) disable iff (rst)
    (rsp.valid && rsp.reason == lrfc_pkg::FR_OVERFLOW
     && $past(is_tr)) |-> rsp.cpl == lrfc_pkg::LRFC_CPL_SUCCESS
       && !rsp.perm_read && !rsp.perm_write;
  endproperty
  a_ovf_tr_noperm: assert property (p_ovf_tr_noperm)
    else $error("overflow translation kept permissions");

  property p_td_ovf;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && legacy && is_td && above_width(req.addr, st_ff.host_addr_width))
      |=> rsp.cpl == lrfc_pkg::LRFC_CPL_UR
          && rsp.reason == lrfc_pkg::FR_OVERFLOW;
  endproperty
  a_td_ovf: assert property (p_td_ovf)
    else $error("translated overflow not UR 4h");

  property p_pt_ovf;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && legacy && is_ut && !chk_walk && !chk_rsvd
     && req.translation_type == lrfc_pkg::TT_PASSTHROUGH
     && above_width(req.addr, st_ff.host_addr_width))
      |=> rsp.cpl == lrfc_pkg::LRFC_CPL_UR
          && rsp.reason == lrfc_pkg::FR_OVERFLOW;
  endproperty
  a_pt_ovf: assert property (p_pt_ovf)
    else $error("pass-through overflow not UR 4h");

  property p_rd_denied;
    @(posedge ref_clk) disable iff (rst)
    (rsp.reason == lrfc_pkg::FR_READ_DENIED)
      |-> $past(req.is_read) && !$past(req.perm_read);
  endproperty
  a_rd_denied: assert property (p_rd_denied)
    else $error("read denial without cause");

  property p_win_cpl;
    @(posedge ref_clk) disable iff (rst)
    (rsp.reason == lrfc_pkg::FR_INTR_WINDOW)
      |-> rsp.cpl == ($past(is_tr) ? lrfc_pkg::LRFC_CPL_CA
                                    : lrfc_pkg::LRFC_CPL_UR);
  endproperty
  a_win_cpl: assert property (p_win_cpl)
    else $error("window fault with wrong completion");

  property p_wr_denied;
    @(posedge ref_clk) disable iff (rst)
    (rsp.reason == lrfc_pkg::FR_WRITE_DENIED)
      |-> $past(req.is_write) && !$past(req.perm_write);
  endproperty
  a_wr_denied: assert property (p_wr_denied)
    else $error("write denial without cause");

  property p_zlr;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && st_ff.zlr_cap && req.zero_len && req.perm_write
     && !req.perm_read) |=> rsp.reason != lrfc_pkg::FR_READ_DENIED;
  endproperty
  a_zlr: assert property (p_zlr)
    else $error("zero-length read to write-only page faulted");

  property p_fault_record;
    @(posedge ref_clk) disable iff (rst)
    (req.valid && legacy && chk_win)
      |=> fault.valid && fault.addr == $past(req.addr);
  endproperty
  a_fault_record: assert property (p_fault_record)
    else $error("fault record missing or wrong address");

  c_walk: cover property (@(posedge ref_clk) disable iff (rst)
    fault.reason == lrfc_pkg::FR_WALK_ACCESS);
  c_window: cover property (@(posedge ref_clk) disable iff (rst)
    fault.reason == lrfc_pkg::FR_INTR_WINDOW);
  c_reg_rd: cover property (@(posedge ref_clk) disable iff (rst)
    avs_read && !avs_waitrequest);

endmodule : lrfc_checker

// File: lrfc_io_dev.sv
// I/O device model: turns bench commands into one-cycle requests.
// Assumes commands change just after the rising edge of ref_clk.
`timescale 1ns/1ns
module lrfc_io_dev (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Command in, request out
  input wire lrfc_pkg::lrfc_req_s cmd,
  output lrfc_pkg::lrfc_req_s req
);
  // Idle fields toggle so a stale request never looks fresh
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      req <= '0;
    else if (cmd.valid)
      req <= cmd;
    else
      req <= {1'b0, ~req[$bits(req)-2:0]};
  end
endmodule : lrfc_io_dev

// File: legacy_remap_fault_checker_test.sv
// Self-checking bench for the legacy remap fault checker.
// Assumes one answer per request, in request order.
`timescale 1ns/1ns
module legacy_remap_fault_checker_test;
  typedef struct packed {
    lrfc_pkg::lrfc_cpl_e cpl;
    logic [7:0] rsn;
    logic [3:0] pm;
    logic [15:0] sid;
    logic [63:0] adr;
  } lrfc_exp_s;
  localparam lrfc_pkg::lrfc_kind_e KU = lrfc_pkg::LRFC_KIND_UNTRANSLATED;
  localparam lrfc_pkg::lrfc_kind_e KT = lrfc_pkg::LRFC_KIND_TRANSLATION;
  localparam lrfc_pkg::lrfc_kind_e KX = lrfc_pkg::LRFC_KIND_TRANSLATED;
  localparam lrfc_pkg::lrfc_cpl_e CS = lrfc_pkg::LRFC_CPL_SUCCESS;
  localparam lrfc_pkg::lrfc_cpl_e CU = lrfc_pkg::LRFC_CPL_UR;
  localparam lrfc_pkg::lrfc_cpl_e CA = lrfc_pkg::LRFC_CPL_CA;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  lrfc_pkg::lrfc_req_s cmd = '0;
  lrfc_pkg::lrfc_req_s req;
  lrfc_pkg::lrfc_rsp_s rsp;
  lrfc_pkg::lrfc_fault_s fault;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  lrfc_exp_s exp_q[$];
  lrfc_exp_s m;
  lrfc_exp_s lst;
  int n_flt = 0;
  lrfc_pkg::lrfc_req_s r;
  logic [31:0] rd;
  integer seed = 73078;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 ref_clk = ~ref_clk;

  lrfc_io_dev u_dev (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .req(req));
  lrfc_checker u_dut (.ref_clk(ref_clk), .rst(rst), .req(req), .rsp(rsp),
    .fault(fault), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  task automatic chk(input logic [127:0] seen, input logic [127:0] want);
    n_tests++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Request held until the edge that sees waitrequest low
  task automatic av(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  function automatic lrfc_pkg::lrfc_req_s nb();
    lrfc_pkg::lrfc_req_s q;
    q = '0;
    q.valid = 1'b1;
    q.is_read = 1'b1;
    q.context_addr_width = 7'h27;
    q.source_id = 16'($random(seed));
    q.addr = {44'h0, 20'($random(seed))};
    q.out_addr = q.addr;
    {q.perm_read, q.perm_write, q.perm_user, q.perm_super} = 4'hf;
    return q;
  endfunction : nb

  task automatic go(input lrfc_pkg::lrfc_kind_e k, input lrfc_pkg::lrfc_cpl_e c,
    input logic [7:0] rs);
    lrfc_exp_s e;
    r.kind = k;
    e.cpl = c;
    e.rsn = rs;
    e.sid = r.source_id;
    e.adr = r.addr;
    e.pm = {r.perm_read, r.perm_write, r.perm_user, r.perm_super};
    if (rs == 8'h04)
      e.pm = 4'h0;
    if (rs != 8'h00)
    begin
      n_flt++;
      lst = e;
    end
    exp_q.push_back(e);
    @(posedge ref_clk);
    cmd <= r;
  endtask : go

  task automatic idle;
    @(posedge ref_clk);
    cmd.valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : idle

  always @(negedge ref_clk)
  begin
    if (!rst && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1, 0);
      else
      begin
        m = exp_q.pop_front();
        chk(rsp.cpl, m.cpl);
        chk(rsp.reason, m.rsn);
        if (m.cpl == CS)
          chk({rsp.perm_read, rsp.perm_write, rsp.perm_user,
            rsp.perm_super}, m.pm);
        chk(fault.valid, m.rsn != 8'h00);
        if (m.rsn != 8'h00)
          chk({fault.reason, fault.source_id, fault.addr},
            {m.rsn, m.sid, m.adr});
      end
    end
    else if (!rst && fault.valid === 1'b1)
      chk(1, 0);
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    av(1'b0, lrfc_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h0027_3000);
    av(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    r = nb();
    r.walk_access_error = 1'b1;
    r.entry_reserved_error = 1'b1;
    go(KU, CU, 8'h07);
    go(KT, CA, 8'h07);
    r.walk_access_error = 1'b0;
    go(KU, CU, 8'h0c);
    go(KT, CA, 8'h0c);
    r = nb();
    r.addr = 64'h80_0000_0000;
    r.out_addr = r.addr;
    go(KU, CU, 8'h04);
    go(KT, CS, 8'h04);
    go(KX, CU, 8'h04);
    r.addr = 64'h7f_ffff_ffff;
    r.out_addr = r.addr;
    go(KU, CS, 8'h00);
    go(KX, CS, 8'h00);
    r.addr = 64'h80_0000_0000;
    r.out_addr = 64'h0;
    r.translation_type = lrfc_pkg::TT_PASSTHROUGH;
    r.context_addr_width = 7'h30;
    go(KU, CU, 8'h04);
    r = nb();
    r.is_read = 1'b0;
    r.is_write = 1'b1;
    r.perm_write = 1'b0;
    go(KU, CU, 8'h05);
    go(KT, CS, 8'h05);
    r.is_read = 1'b1;
    go(KU, CU, 8'h05);
    r = nb();
    r.perm_read = 1'b0;
    go(KU, CU, 8'h06);
    go(KT, CS, 8'h06);
    r.is_write = 1'b1;
    go(KU, CU, 8'h06);
    r = nb();
    r.out_addr = 64'hfee0_1000;
    go(KU, CU, 8'h0e);
    go(KT, CA, 8'h0e);
    r.addr = 64'hfeef_ffff;
    r.out_addr = 64'h0;
    go(KU, CS, 8'h00);
    go(KX, CU, 8'h0e);
    r.translation_type = lrfc_pkg::TT_PASSTHROUGH;
    go(KU, CU, 8'h0e);
    r = nb();
    r.zero_len = 1'b1;
    r.perm_read = 1'b0;
    go(KU, CU, 8'h06);
    idle();
    av(1'b1, lrfc_pkg::OFF_CTRL, 32'h0027_3004);
    go(KU, CS, 8'h00);
    r.perm_write = 1'b0;
    go(KU, CU, 8'h06);
    idle();
    av(1'b1, lrfc_pkg::OFF_CTRL, 32'h0027_3001);
    r = nb();
    r.walk_access_error = 1'b1;
    go(KU, CS, 8'h00);
    idle();
    av(1'b1, lrfc_pkg::OFF_CTRL, 32'h0027_3000);
    go(KU, CU, 8'h07);
    repeat (20)
    begin
      r = nb();
      go(KU, CS, 8'h00);
    end
    idle();
    chk(exp_q.size(), 0);
    av(1'b0, lrfc_pkg::OFF_STATUS, 32'h0);
    chk(rd, {8'h00, lst.rsn, 16'(n_flt)});
    av(1'b0, lrfc_pkg::OFF_FADDR_LO, 32'h0);
    chk(rd, lst.adr[31:0]);
    av(1'b0, lrfc_pkg::OFF_FADDR_HI, 32'h0);
    chk(rd, lst.adr[63:32]);
    av(1'b0, lrfc_pkg::OFF_FSRC, 32'h0);
    chk(rd, {16'h0000, lst.sid});
    av(1'b1, lrfc_pkg::OFF_STATUS, 32'h0);
    av(1'b0, lrfc_pkg::OFF_STATUS, 32'h0);
    chk(rd, {8'h00, lst.rsn, 16'h0000});
    report_and_stop();
  end
endmodule : legacy_remap_fault_checker_test
